// ==== logic/dual_timer_sync_start.sv ====
// module: two timer units with shared synchronous start, apb slave
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps

module dual_timer_sync_start
  import dual_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dual_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic main_ch3_output_pin,
  output logic secondary_ch3_output_pin
);
  import dual_timer_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] main_run;
    logic [7:0] sec_run;
    logic [7:0] sync_req;
    logic [1:0] clock_stop;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  channel_if ch_main ();
  channel_if ch_sec ();

  logic acc;
  logic wr;
  logic rd;
  logic full_word;
  logic [ADDR_W-1:0] unit_off;
  logic sel_main;
  logic sel_sec;
  logic [7:0] sync_wr;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // read data is captured on the first access edge, a write commits on the completing edge
  assign acc = psel && penable && !st_ff.ready;
  assign wr = psel && penable && pwrite && st_ff.ready;
  assign rd = acc && !pwrite;
  assign full_word = (pstrb[1:0] == 2'b11);
  assign sel_main = (paddr >= OFF_MAIN_RUN) && (paddr <= OFF_MAIN_CNT);
  assign sel_sec = (paddr >= OFF_SEC_RUN) && (paddr <= OFF_SEC_CNT);
  assign unit_off = sel_sec ? paddr - OFF_SEC_RUN + OFF_MAIN_RUN : paddr;
  assign sync_wr = (wr && paddr == OFF_SYNC_START) ? (pwdata[7:0] & SYNC_VALID_MASK) : 8'h00;

  // ----------------------------------------
  // channel write strobes
  // ----------------------------------------
  // the secondary unit reuses the main channel 3 register layout
  always_comb
  begin
    ch_main.wdata = pwdata[15:0];
    ch_sec.wdata = pwdata[15:0];
    ch_main.cnt_we = wr && full_word && sel_main && unit_off == OFF_MAIN_CNT;
    ch_main.cmpa_we = wr && full_word && sel_main && unit_off == OFF_MAIN_CMPA;
    ch_main.ioctl_we = wr && full_word && sel_main && unit_off == OFF_MAIN_IOCTL;
    ch_main.ctrl_we = wr && pstrb[0] && sel_main && unit_off == OFF_MAIN_CTRL;
    ch_main.mode_we = wr && pstrb[0] && sel_main && unit_off == OFF_MAIN_MODE;
    ch_sec.cnt_we = wr && full_word && sel_sec && unit_off == OFF_MAIN_CNT;
    ch_sec.cmpa_we = wr && full_word && sel_sec && unit_off == OFF_MAIN_CMPA;
    ch_sec.ioctl_we = wr && full_word && sel_sec && unit_off == OFF_MAIN_IOCTL;
    ch_sec.ctrl_we = wr && pstrb[0] && sel_sec && unit_off == OFF_MAIN_CTRL;
    ch_sec.mode_we = wr && pstrb[0] && sel_sec && unit_off == OFF_MAIN_MODE;
    ch_main.tick = !st_ff.clock_stop[STOP_MAIN];
    ch_sec.tick = !st_ff.clock_stop[STOP_SEC];
    ch_main.run = st_ff.main_run[RUN_BIT_CH3];
    ch_sec.run = st_ff.sec_run[RUN_BIT_CH3];
  end

  timer_channel3 u_main_ch3 (
    .pclk(pclk),
    .presetn(presetn),
    .ch(ch_main)
  );

  timer_channel3 u_sec_ch3 (
    .pclk(pclk),
    .presetn(presetn),
    .ch(ch_sec)
  );

  // ----------------------------------------
  // run control and synchronous start
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ready = acc;
    nxt_st.err = 1'b0;
    // a request bit is served once its run bit has been set and the unit is clocked
    if (st_ff.sync_req[SYNC_SEC_CH3] && st_ff.sec_run[RUN_BIT_CH3] && !st_ff.clock_stop[STOP_SEC])
      nxt_st.sync_req[SYNC_SEC_CH3] = 1'b0;
    if (st_ff.sync_req[SYNC_SEC_CH4] && st_ff.sec_run[RUN_BIT_CH4] && !st_ff.clock_stop[STOP_SEC])
      nxt_st.sync_req[SYNC_SEC_CH4] = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      if (st_ff.sync_req[SYNC_MAIN_LSB + i] && !st_ff.clock_stop[STOP_MAIN] &&
          st_ff.main_run[(i < 3) ? i : i + 3])
        nxt_st.sync_req[SYNC_MAIN_LSB + i] = 1'b0;
    end
    if (wr && pstrb[0])
    begin
      case (paddr)
        OFF_MAIN_RUN: nxt_st.main_run = pwdata[7:0] & MAIN_RUN_MASK;
        OFF_SEC_RUN: nxt_st.sec_run = pwdata[7:0] & SEC_RUN_MASK;
        OFF_CLOCK_STOP: nxt_st.clock_stop = pwdata[1:0];
        default: nxt_st.clock_stop = st_ff.clock_stop;
      endcase
    end
    // one write sets run bits of both units on the same edge, any mode; set wins
    nxt_st.sync_req = nxt_st.sync_req | sync_wr;
    nxt_st.main_run = nxt_st.main_run | {sync_wr[7:6], 3'b000, sync_wr[5:3]};
    nxt_st.sec_run = nxt_st.sec_run | {sync_wr[1:0], 6'b000000};
    if (rd)
    begin
      case (unit_off)
        OFF_MAIN_RUN: nxt_st.rdata = {24'h00_0000, sel_sec ? st_ff.sec_run : st_ff.main_run};
        OFF_MAIN_CNT: nxt_st.rdata = {16'h0000, sel_sec ? ch_sec.cnt : ch_main.cnt};
        OFF_MAIN_CMPA: nxt_st.rdata = {16'h0000, sel_sec ? ch_sec.cmpa : ch_main.cmpa};
        OFF_MAIN_IOCTL: nxt_st.rdata = {16'h0000, sel_sec ? ch_sec.ioctl : ch_main.ioctl};
        OFF_MAIN_CTRL: nxt_st.rdata = {24'h00_0000, sel_sec ? ch_sec.ctrl : ch_main.ctrl};
        OFF_MAIN_MODE: nxt_st.rdata = {24'h00_0000, sel_sec ? ch_sec.mode : ch_main.mode};
        OFF_SYNC_START: nxt_st.rdata = {24'h00_0000, st_ff.sync_req};
        OFF_CLOCK_STOP: nxt_st.rdata = {30'h0000_0000, st_ff.clock_stop};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && !sel_main && !sel_sec && paddr != OFF_SYNC_START &&
        paddr != OFF_CLOCK_STOP)
      nxt_st.err = 1'b1;
    if (acc && (sel_main || sel_sec) && (paddr[1:0] != 2'b00))
      nxt_st.err = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '{main_run: 8'h00, sec_run: 8'h00, sync_req: 8'h00,
        clock_stop: CLOCK_STOP_RESET, rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0};
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign main_ch3_output_pin = ch_main.pin;
  assign secondary_ch3_output_pin = ch_sec.pin;
endmodule // dual_timer_sync_start

// ==== pkg/dual_timer_pkg.sv ====
// package: register map, field layout and reset values of the dual timer
package dual_timer_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_SYNC_START = 12'h000;
  localparam logic [11:0] OFF_CLOCK_STOP = 12'h004;
  localparam logic [11:0] OFF_MAIN_RUN = 12'h010;
  localparam logic [11:0] OFF_MAIN_CTRL = 12'h014;
  localparam logic [11:0] OFF_MAIN_MODE = 12'h018;
  localparam logic [11:0] OFF_MAIN_IOCTL = 12'h01c;
  localparam logic [11:0] OFF_MAIN_CMPA = 12'h020;
  localparam logic [11:0] OFF_MAIN_CNT = 12'h024;
  localparam logic [11:0] OFF_SEC_RUN = 12'h030;
  localparam logic [11:0] OFF_SEC_CTRL = 12'h034;
  localparam logic [11:0] OFF_SEC_MODE = 12'h038;
  localparam logic [11:0] OFF_SEC_IOCTL = 12'h03c;
  localparam logic [11:0] OFF_SEC_CMPA = 12'h040;
  localparam logic [11:0] OFF_SEC_CNT = 12'h044;
  localparam logic [11:0] UNIT_STRIDE = 12'h020;
  // run / sync-start bit positions
  localparam int unsigned RUN_BIT_CH3 = 6;
  localparam int unsigned RUN_BIT_CH4 = 7;
  localparam logic [7:0] MAIN_SYNC_MASK = 8'h07;
  localparam logic [7:0] MAIN_RUN_MASK = 8'hc7;
  localparam logic [7:0] SEC_RUN_MASK = 8'hc0;
  // sync-start layout: bits 7:3 main ch4,ch3,ch2,ch1,ch0 ; bits 1:0 sec ch4,ch3
  localparam logic [7:0] SYNC_VALID_MASK = 8'hfb;
  localparam int unsigned SYNC_MAIN_LSB = 3;
  localparam int unsigned SYNC_SEC_CH3 = 0;
  localparam int unsigned SYNC_SEC_CH4 = 1;
  // clock stop bits
  localparam int unsigned STOP_MAIN = 0;
  localparam int unsigned STOP_SEC = 1;
  localparam logic [1:0] CLOCK_STOP_RESET = 2'h3;
  // field values
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [2:0] CLEAR_ON_CMPA = 3'h1;
  localparam logic [3:0] IOA_TOGGLE_HIGH = 4'h7;
  localparam int unsigned CLEAR_LSB = 5;
  localparam logic [15:0] CMPA_RESET = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] IOCTL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

// ==== pkg/channel_if.sv ====
// interface: software access and run control of one timer channel
`timescale 1ns/100ps
interface channel_if;
  logic run;
  logic tick;
  logic cnt_we;
  logic cmpa_we;
  logic ioctl_we;
  logic ctrl_we;
  logic mode_we;
  logic [15:0] wdata;
  logic [15:0] cnt;
  logic [15:0] cmpa;
  logic [15:0] ioctl;
  logic [7:0] ctrl;
  logic [7:0] mode;
  logic pin;
  modport unit (input run, tick, cnt_we, cmpa_we, ioctl_we, ctrl_we, mode_we, wdata,
    output cnt, cmpa, ioctl, ctrl, mode, pin);
  modport host (output run, tick, cnt_we, cmpa_we, ioctl_we, ctrl_we, mode_we, wdata,
    input cnt, cmpa, ioctl, ctrl, mode, pin);
endinterface

// ==== logic/timer_channel3.sv ====
// module: one channel 3 counter with compare A clear and toggle output
`timescale 1ns/100ps
module timer_channel3
  import dual_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  channel_if.unit ch
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [15:0] ioctl;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic pin;
  } chan_state_t;

  chan_state_t st_ff;
  chan_state_t nxt_st;
  logic match;
  logic [3:0] io_control_a_field;

  always_comb
  begin
    nxt_st = st_ff;
    io_control_a_field = st_ff.ioctl[3:0];
    match = ch.run && ch.tick && (st_ff.cnt == st_ff.cmpa);
    if (ch.run && ch.tick)
    begin
      if (match && st_ff.ctrl[CLEAR_LSB +: 3] == CLEAR_ON_CMPA)
        nxt_st.cnt = 16'h0000;
      else
        nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    if (match && st_ff.mode[3:0] == MODE_NORMAL && io_control_a_field == IOA_TOGGLE_HIGH)
      nxt_st.pin = ~st_ff.pin;
    if (ch.cnt_we)
      nxt_st.cnt = ch.wdata;
    if (ch.cmpa_we)
      nxt_st.cmpa = ch.wdata;
    if (ch.ioctl_we)
    begin
      nxt_st.ioctl = ch.wdata;
      if (ch.wdata[3:0] == IOA_TOGGLE_HIGH)
        nxt_st.pin = 1'b1;
      else if (ch.wdata[3:0] == 4'h0)
        nxt_st.pin = st_ff.pin;
      else
        nxt_st.pin = 1'b0;
    end
    if (ch.ctrl_we)
      nxt_st.ctrl = ch.wdata[7:0];
    if (ch.mode_we)
      nxt_st.mode = ch.wdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '{cnt: CNT_RESET, cmpa: CMPA_RESET, ioctl: IOCTL_RESET, ctrl: CTRL_RESET,
        mode: MODE_RESET, pin: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign ch.cnt = st_ff.cnt;
  assign ch.cmpa = st_ff.cmpa;
  assign ch.ioctl = st_ff.ioctl;
  assign ch.ctrl = st_ff.ctrl;
  assign ch.mode = st_ff.mode;
  assign ch.pin = st_ff.pin;
endmodule // timer_channel3

// ==== bench/dual_timer_checker.sv ====
// checker: bus and frozen-unit assertions of the dual timer
`timescale 1ns/100ps
module dual_timer_checker
  import dual_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dual_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic main_ch3_output_pin,
  input wire logic secondary_ch3_output_pin
);
  logic [1:0] stop_ff;
  wire logic done = psel && penable && pready && pwrite;
  // shadow of the clock stop bits, as software last wrote them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) stop_ff <= CLOCK_STOP_RESET;
    else if (done && paddr == OFF_CLOCK_STOP && pstrb[0]) stop_ff <= pwdata[1:0];
  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'b00 && (a <= 12'h004 || (a >= 12'h010 && a <= 12'h024)
      || (a >= 12'h030 && a <= 12'h044));
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first;
    psel && penable && !pready;
  endsequence
  a_ready_wait: assert property (s_first |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_unmapped_err: assert property (s_first ##0 !mapped(paddr) |=> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (s_first ##0 mapped(paddr) |=> !pslverr)
    else $error("error on mapped");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_main_frozen: assert property (stop_ff[STOP_MAIN] && !(done && paddr == OFF_MAIN_IOCTL)
    |=> $stable(main_ch3_output_pin)) else $error("main pin moved while stopped");
  a_sec_frozen: assert property (stop_ff[STOP_SEC] && !(done && paddr == OFF_SEC_IOCTL)
    |=> $stable(secondary_ch3_output_pin)) else $error("sec pin moved while stopped");
endmodule // dual_timer_checker

// ==== bench/tb_dual_timer_sync_start.sv ====
// testbench: registers, synchronous start and waveforms of the dual timer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_dual_timer_sync_start;
  import dual_timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, p;
  logic main_ch3_output_pin, secondary_ch3_output_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, held;
  logic [3:0] pstrb;
  int n_fail = 0;
  int checks_done = 0;
  int gap;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [3:0] s;
    logic [31:0] e; logic x;} row_t;
  row_t rows [9] = '{
    '{1'b0, OFF_CLOCK_STOP, 32'h0000_0000, 4'hf, 32'h0000_0003, 1'b0},
    '{1'b0, OFF_MAIN_CMPA, 32'h0000_0000, 4'hf, 32'h0000_ffff, 1'b0},
    '{1'b0, OFF_SEC_CMPA, 32'h0000_0000, 4'hf, 32'h0000_ffff, 1'b0},
    '{1'b1, OFF_MAIN_CMPA, 32'h0000_1234, 4'hf, 32'h0000_1234, 1'b0},
    '{1'b1, OFF_MAIN_CMPA, 32'h0000_abcd, 4'h1, 32'h0000_1234, 1'b0},
    '{1'b1, OFF_SEC_CNT, 32'h0000_0055, 4'hf, 32'h0000_0055, 1'b0},
    '{1'b1, OFF_MAIN_RUN, 32'h0000_00ff, 4'hf, 32'h0000_00c7, 1'b0},
    '{1'b1, OFF_SEC_RUN, 32'h0000_00ff, 4'hf, 32'h0000_00c0, 1'b0},
    '{1'b1, 12'h008, 32'h0000_0001, 4'hf, 32'h0000_0000, 1'b1}};
  dual_timer_sync_start dual_timer_sync_start_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .main_ch3_output_pin,
    .secondary_ch3_output_pin);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    n = 0;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        xfer(1'b1, rows[i].a, rows[i].d, rows[i].s);
        `CHK("wr err", rows[i].x, err)
      end
      xfer(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("rd err", rows[i].x, err)
      `CHK("rd data", rows[i].e, rd)
    end
    xfer(1'b1, OFF_MAIN_RUN, 32'h0000_0000);
    xfer(1'b1, OFF_SEC_RUN, 32'h0000_0000);
    for (int u = 0; u < 2; u++)
    begin
      xfer(1'b1, OFF_MAIN_CTRL + 12'(u) * UNIT_STRIDE, 32'(CLEAR_ON_CMPA) << CLEAR_LSB);
      xfer(1'b1, OFF_MAIN_MODE + 12'(u) * UNIT_STRIDE, 32'(MODE_NORMAL));
      xfer(1'b1, OFF_MAIN_CMPA + 12'(u) * UNIT_STRIDE, 32'h0000_0004);
      xfer(1'b1, OFF_MAIN_CNT + 12'(u) * UNIT_STRIDE, 32'h0000_0000);
      xfer(1'b1, OFF_MAIN_IOCTL + 12'(u) * UNIT_STRIDE, 32'(IOA_TOGGLE_HIGH));
    end
    @(posedge pclk);
    `CHK("main pin", 1'b1, main_ch3_output_pin)
    `CHK("sec pin", 1'b1, secondary_ch3_output_pin)
    xfer(1'b1, OFF_CLOCK_STOP, 32'h0000_0000);
    xfer(1'b1, OFF_SYNC_START, 32'h1 << (SYNC_MAIN_LSB + 3) | 32'h1 << SYNC_SEC_CH3);
    repeat (30) @(posedge pclk) `CHK("pins", main_ch3_output_pin, secondary_ch3_output_pin)
    for (int k = 0; k < 2; k++)
    begin
      gap = 0;
      p = main_ch3_output_pin;
      while (main_ch3_output_pin === p && gap < 50)
      begin
        @(posedge pclk);
        gap++;
      end
    end
    `CHK("period", 5, gap)
    xfer(1'b0, OFF_SYNC_START, 32'h0000_0000);
    `CHK("sync", 32'h0000_0000, rd)
    xfer(1'b0, OFF_SEC_RUN, 32'h0000_0000);
    `CHK("sec run", 32'h0000_0040, rd)
    xfer(1'b1, OFF_MAIN_RUN, 32'h0000_0000);
    xfer(1'b0, OFF_MAIN_CNT, 32'h0000_0000);
    held = rd;
    xfer(1'b0, OFF_MAIN_CNT, 32'h0000_0000);
    `CHK("held cnt", held, rd)
    xfer(1'b1, OFF_CLOCK_STOP, 32'h0000_0003);
    repeat (10) @(posedge pclk);
    complete_run;
  end
endmodule // tb_dual_timer_sync_start
bind dual_timer_sync_start dual_timer_checker dual_timer_checker_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .main_ch3_output_pin(main_ch3_output_pin),
  .secondary_ch3_output_pin(secondary_ch3_output_pin));
